// File: shared/cpucd_regs.svh
`ifndef CPUCD_REGS_SVH
`define CPUCD_REGS_SVH
// major opcodes, bits 23:20 of the instruction word
`define CPUCD_OP_NOP 4'h0
`define CPUCD_OP_ALU 4'h1
`define CPUCD_OP_ALUM 4'h2
`define CPUCD_OP_MOVI 4'h3
`define CPUCD_OP_LD 4'h4
`define CPUCD_OP_ST 4'h5
`define CPUCD_OP_MUL 4'h6
`define CPUCD_OP_SHF 4'h7
`define CPUCD_OP_BRA 4'h8
`define CPUCD_OP_CALL 4'h9
`define CPUCD_OP_REP 4'ha
`define CPUCD_OP_DIV 4'hb
`define CPUCD_OP_PAGE 4'hc
`define CPUCD_OP_MOVD 4'hd
`define CPUCD_OP_RET 4'he
// alu sub-functions, bits 19:16
`define CPUCD_ALU_ADD 4'h0
`define CPUCD_ALU_SUB 4'h1
`define CPUCD_ALU_AND 4'h2
`define CPUCD_ALU_OR 4'h3
`define CPUCD_ALU_XOR 4'h4
// branch conditions, bits 19:16
`define CPUCD_BR_ALWAYS 4'h0
`define CPUCD_BR_ZERO 4'h1
`define CPUCD_BR_NZERO 4'h2
// stack pointer register and its reset value
`define CPUCD_SP_IDX 4'hf
`define CPUCD_SP_RESET 16'h0800
// interrupt vector, program word address
`define CPUCD_IRQ_VEC 23'h00_0004
// divider: load step, 16 bit steps, write-back step
`define CPUCD_DIV_LAST 5'h11
`define CPUCD_SHIFT_MAX 5'h10
// dma ram region, byte addresses
`define CPUCD_DMA_BASE 16'h4000
`define CPUCD_DMA_SIZE 16'h0800
`endif

// File: shared/cpucd_pkg.sv
package cpucd_pkg;
   // sequencer states
   typedef enum logic [1:0] {ST_RUN, ST_PUSH2, ST_POP2, ST_MOVD} cpucd_state_e;
   // instruction word fields
   typedef struct packed {
      logic [3:0] op;
      logic [3:0] sub;
      logic [3:0] rd;
      logic [3:0] ext;
      logic [3:0] ra;
      logic [3:0] rb;
   } cpucd_insn_s;
   // data memory write port
   typedef struct packed {
      logic we;
      logic [15:0] addr;
      logic [15:0] data;
   } cpucd_dmw_s;
endpackage

// File: hw/cpucd_core.sv
`timescale 1ns/1ns
`include "cpucd_regs.svh"
module cpucd_core (
   // clock, reset, enable
   input wire logic SYS_CLK,
   input wire logic RST_B,
   input wire logic CLK_EN,
   // program fetch port
   output logic [22:0] PM_ADDR,
   input wire logic [23:0] PM_RDATA,
   // program window read port
   output logic [22:0] PW_ADDR,
   input wire logic [23:0] PW_RDATA,
   // data memory
   output logic [15:0] DM_RADDR,
   input wire logic [15:0] DM_RDATA,
   output cpucd_pkg::cpucd_dmw_s DM_WR,
   output logic DM_DMA_REGION,
   // interrupt
   input wire logic IRQ_REQ,
   output logic IRQ_ACK,
   // status
   output logic REPEAT_BUSY
);
   import cpucd_pkg::*;

   logic [15:0] wreg [16]; // working registers
   logic [22:0] ip_reg; // fetch address
   logic [22:0] ex_pc_reg; // address of ir_reg
   cpucd_insn_s ir_reg; // prefetched instruction
   logic ir_vld_reg; // ir_reg holds a live word
   cpucd_state_e state_reg;
   cpucd_state_e state_next;
   logic [13:0] rep_reg; // remaining extra executions
   logic rep_sus_reg; // repeat parked while an interrupt handler runs
   logic rep_live; // repeat count applies to ir_reg
   logic [4:0] div_step_reg;
   logic [16:0] div_rem_reg;
   logic [15:0] div_quo_reg;
   logic [7:0] page_reg; // program window page
   logic win_en_reg; // window mapping on
   logic z_reg; // zero flag
   logic ie_reg; // interrupts allowed
   logic [6:0] hi_reg; // upper return address bits
   logic [22:0] tgt_reg; // pending target or movd address
   logic [15:0] ra_v, rb_v, rd_v, sp_v; // register reads
   logic ex; // instruction executes this cycle
   logic take_irq;
   logic stay; // ir_reg is not retired this cycle
   logic adv; // load the prefetched word
   logic redirect;
   logic [22:0] redir_tgt;
   logic [15:0] daddr; // data byte address
   logic win_hit;
   logic [15:0] rdata;
   cpucd_dmw_s dmw;
   logic wa_en, wb_en;
   logic [3:0] wa_idx, wb_idx;
   logic [15:0] wa_dat, wb_dat;
   logic signed [33:0] prod;
   logic [15:0] shf;
   logic [4:0] amt;
   logic [16:0] dsh; // divider shifted remainder
   logic dge; // divider subtract fits

   // two-operand alu
   function automatic logic [15:0] alu_f(input logic [3:0] f,
                                         input logic [15:0] a,
                                         input logic [15:0] b);
      logic [15:0] r;
      r = 16'h0000;
      unique case (f)
         `CPUCD_ALU_ADD: r = a + b;
         `CPUCD_ALU_SUB: r = a - b;
         `CPUCD_ALU_AND: r = a & b;
         `CPUCD_ALU_OR: r = a | b;
         `CPUCD_ALU_XOR: r = a ^ b;
         default: r = a;
      endcase
      return r;
   endfunction

   // register file reads, any register as data, pointer or offset
   assign ra_v = wreg[ir_reg.ra];
   assign rb_v = wreg[ir_reg.rb];
   assign rd_v = wreg[ir_reg.rd];
   assign sp_v = wreg[`CPUCD_SP_IDX];

   // execute gating; an interrupt takes the slot instead
   assign take_irq = IRQ_REQ && ie_reg && ir_vld_reg && state_reg == ST_RUN;
   assign ex = ir_vld_reg && state_reg == ST_RUN && !take_irq;
   assign IRQ_ACK = take_irq && CLK_EN;
   assign REPEAT_BUSY = rep_reg != 14'h0000;
   // a parked count must not be eaten by the handler's own instructions
   assign rep_live = rep_reg != 14'h0000 && !rep_sus_reg;

   // mixed-sign multiply by sign extension to 17 bits
   assign prod = $signed({ir_reg.sub[0] & ra_v[15], ra_v}) *
                 $signed({ir_reg.sub[1] & rb_v[15], rb_v});

   // one-cycle barrel shift, amount capped at 16
   assign amt = (rb_v[4:0] > `CPUCD_SHIFT_MAX) ? `CPUCD_SHIFT_MAX : rb_v[4:0];
   always_comb begin
      if (ir_reg.sub[0]) begin
         shf = ra_v << amt;
      end else if (ir_reg.sub[1]) begin
         shf = 16'($signed(ra_v) >>> amt);
      end else begin
         shf = ra_v >> amt;
      end
   end

   // restoring divide step
   assign dsh = {div_rem_reg[15:0], div_quo_reg[15]};
   assign dge = dsh >= {1'b0, rb_v};

   // data address, word aligned byte address in 64K bytes
   always_comb begin
      daddr = ra_v;
      unique case (state_reg)
         ST_POP2: daddr = sp_v - 16'h0002;
         ST_MOVD: daddr = tgt_reg[15:0];
         default: begin
            if (ir_reg.op == `CPUCD_OP_LD || ir_reg.op == `CPUCD_OP_ST) begin
               daddr = ra_v + rb_v;
            end else if (ir_reg.op == `CPUCD_OP_RET) begin
               daddr = sp_v - 16'h0002;
            end
         end
      endcase
   end

   // program window: upper 32K bytes onto a 16K-word page
   assign win_hit = win_en_reg && daddr[15];
   assign PW_ADDR = {1'b0, page_reg, daddr[14:1]};
   assign rdata = win_hit ? PW_RDATA[15:0] : DM_RDATA;
   assign DM_RADDR = daddr;
   // dma ram is plain data memory to the core, only flagged
   assign DM_DMA_REGION = daddr >= `CPUCD_DMA_BASE &&
                          daddr < `CPUCD_DMA_BASE + `CPUCD_DMA_SIZE;
   assign PM_ADDR = ip_reg;
   assign DM_WR = '{we: dmw.we & CLK_EN, addr: dmw.addr, data: dmw.data};

   // decode and control
   always_comb begin
      state_next = state_reg;
      stay = 1'b0;
      redirect = 1'b0;
      redir_tgt = ip_reg;
      dmw = '{we: 1'b0, addr: 16'h0000, data: 16'h0000};
      wa_en = 1'b0;
      wa_idx = ir_reg.rd;
      wa_dat = 16'h0000;
      wb_en = 1'b0;
      wb_idx = `CPUCD_SP_IDX;
      wb_dat = 16'h0000;
      unique case (state_reg)
         ST_RUN: begin
            if (take_irq) begin
               // save the unexecuted instruction's address
               dmw = '{we: 1'b1, addr: sp_v, data: ex_pc_reg[15:0]};
               wb_en = 1'b1;
               wb_dat = sp_v + 16'h0002;
               state_next = ST_PUSH2;
            end else if (ex) begin
               stay = rep_live && ir_reg.op != `CPUCD_OP_REP;
               unique case (ir_reg.op)
                  `CPUCD_OP_ALU: begin
                     wa_en = 1'b1;
                     wa_dat = alu_f(ir_reg.sub, ra_v, rb_v);
                  end
                  `CPUCD_OP_ALUM: begin
                     // memory read, register read, memory write at once
                     dmw = '{we: 1'b1, addr: rd_v,
                             data: alu_f(ir_reg.sub, rdata, rb_v)};
                  end
                  `CPUCD_OP_MOVI: begin
                     wa_en = 1'b1;
                     wa_idx = ir_reg.sub;
                     wa_dat = {ir_reg.ext, ir_reg.ra, ir_reg.rb, ir_reg.rd};
                  end
                  `CPUCD_OP_LD: begin
                     wa_en = 1'b1;
                     wa_dat = rdata;
                  end
                  `CPUCD_OP_ST: dmw = '{we: 1'b1, addr: daddr, data: rd_v};
                  `CPUCD_OP_MUL: begin
                     wa_en = 1'b1;
                     wa_dat = prod[15:0];
                     wb_en = 1'b1;
                     wb_idx = ir_reg.rd + 4'h1;
                     wb_dat = prod[31:16];
                  end
                  `CPUCD_OP_SHF: begin
                     wa_en = 1'b1;
                     wa_dat = shf;
                  end
                  `CPUCD_OP_BRA: begin
                     if (ir_reg.sub == `CPUCD_BR_ALWAYS ||
                         (ir_reg.sub == `CPUCD_BR_ZERO && z_reg) ||
                         (ir_reg.sub == `CPUCD_BR_NZERO && !z_reg)) begin
                        redirect = 1'b1;
                        redir_tgt = ex_pc_reg + 23'h00_0001 +
                                    {{7{ir_reg.rd[3]}}, ir_reg[15:0]};
                     end
                  end
                  `CPUCD_OP_CALL: begin
                     stay = 1'b1;
                     dmw = '{we: 1'b1, addr: sp_v, data: ip_reg[15:0]};
                     wb_en = 1'b1;
                     wb_dat = sp_v + 16'h0002;
                     state_next = ST_PUSH2;
                  end
                  `CPUCD_OP_DIV: begin
                     if (div_step_reg == `CPUCD_DIV_LAST) begin
                        wa_en = 1'b1;
                        wa_idx = 4'h0;
                        wa_dat = div_quo_reg;
                        wb_en = 1'b1;
                        wb_idx = 4'h1;
                        wb_dat = div_rem_reg[15:0];
                     end
                  end
                  `CPUCD_OP_MOVD: begin
                     stay = 1'b1;
                     wa_en = 1'b1;
                     wa_dat = rdata;
                     state_next = ST_MOVD;
                  end
                  `CPUCD_OP_RET: begin
                     stay = 1'b1;
                     wb_en = 1'b1;
                     wb_dat = sp_v - 16'h0002;
                     state_next = ST_POP2;
                  end
                  default: ;
               endcase
            end
         end
         ST_PUSH2: begin
            // upper return bits, then jump
            dmw = '{we: 1'b1, addr: sp_v, data: {9'h000, hi_reg}};
            wb_en = 1'b1;
            wb_dat = sp_v + 16'h0002;
            redirect = 1'b1;
            redir_tgt = tgt_reg;
            state_next = ST_RUN;
         end
         ST_POP2: begin
            wb_en = 1'b1;
            wb_dat = sp_v - 16'h0002;
            redirect = 1'b1;
            redir_tgt = {hi_reg, rdata};
            state_next = ST_RUN;
         end
         ST_MOVD: begin
            wa_en = 1'b1;
            wa_idx = ir_reg.rd + 4'h1;
            wa_dat = rdata;
            state_next = ST_RUN;
         end
      endcase
   end

   assign adv = (state_reg == ST_RUN && (!ir_vld_reg || (ex && !stay))) ||
                state_reg == ST_MOVD;

   // fetch: prefetch one word ahead, flush on redirect
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         ip_reg <= 23'h00_0000;
         ex_pc_reg <= 23'h00_0000;
         ir_reg <= '0;
         ir_vld_reg <= 1'b0;
      end else if (CLK_EN) begin
         if (redirect) begin
            ip_reg <= redir_tgt;
            ir_vld_reg <= 1'b0;
         end else if (adv) begin
            ir_reg <= PM_RDATA;
            ex_pc_reg <= ip_reg;
            ip_reg <= ip_reg + 23'h00_0001;
            ir_vld_reg <= 1'b1;
         end
      end
   end

   // sequencer state
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         state_reg <= ST_RUN;
      end else if (CLK_EN) begin
         state_reg <= state_next;
      end
   end

   // register file, two write ports
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         for (int i = 0; i < 16; i++) begin
            wreg[i] <= 16'h0000;
         end
         wreg[`CPUCD_SP_IDX] <= `CPUCD_SP_RESET;
      end else if (CLK_EN) begin
         if (wa_en) begin
            wreg[wa_idx] <= wa_dat;
         end
         if (wb_en) begin
            wreg[wb_idx] <= wb_dat;
         end
      end
   end

   // repeat counter; parked on interrupt entry, freed by interrupt return
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         rep_reg <= 14'h0000;
         rep_sus_reg <= 1'b0;
      end else if (CLK_EN) begin
         if (take_irq) begin
            rep_sus_reg <= rep_reg != 14'h0000;
         end else if (ex) begin
            if (ir_reg.op == `CPUCD_OP_RET && ir_reg.sub[0]) begin
               rep_sus_reg <= 1'b0;
            end
            if (ir_reg.op == `CPUCD_OP_REP) begin
               rep_reg <= {ir_reg.ext[1:0], ir_reg.ra, ir_reg.rb, ir_reg.rd};
            end else if (rep_live) begin
               rep_reg <= rep_reg - 14'h0001;
            end
         end
      end
   end

   // divider: load, 16 shift-subtract steps, write-back
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         div_step_reg <= 5'h00;
         div_rem_reg <= 17'h0_0000;
         div_quo_reg <= 16'h0000;
      end else if (CLK_EN && ex && ir_reg.op == `CPUCD_OP_DIV) begin
         if (div_step_reg == `CPUCD_DIV_LAST) begin
            div_step_reg <= 5'h00;
         end else begin
            div_step_reg <= div_step_reg + 5'h01;
         end
         if (div_step_reg == 5'h00) begin
            // 32/16 takes the upper dividend from ra+1
            div_rem_reg <= ir_reg.sub[0] ? {1'b0, wreg[ir_reg.ra + 4'h1]} : 17'h0_0000;
            div_quo_reg <= ra_v;
         end else if (div_step_reg != `CPUCD_DIV_LAST) begin
            div_rem_reg <= dge ? dsh - {1'b0, rb_v} : dsh;
            div_quo_reg <= {div_quo_reg[14:0], dge};
         end
      end
   end

   // flags, page, interrupt enable, return and target latches
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         page_reg <= 8'h00;
         win_en_reg <= 1'b0;
         z_reg <= 1'b0;
         ie_reg <= 1'b1;
         hi_reg <= 7'h00;
         tgt_reg <= 23'h00_0000;
      end else if (CLK_EN) begin
         if (take_irq) begin
            ie_reg <= 1'b0;
            hi_reg <= ex_pc_reg[22:16];
            tgt_reg <= `CPUCD_IRQ_VEC;
         end else if (ex) begin
            unique case (ir_reg.op)
               `CPUCD_OP_ALU: z_reg <= alu_f(ir_reg.sub, ra_v, rb_v) == 16'h0000;
               `CPUCD_OP_PAGE: begin
                  page_reg <= {ir_reg.ra, ir_reg.rb};
                  win_en_reg <= ir_reg.ext[0];
               end
               `CPUCD_OP_CALL: begin
                  hi_reg <= ip_reg[22:16];
                  tgt_reg <= {3'h0, ir_reg[19:0]};
               end
               `CPUCD_OP_MOVD: tgt_reg <= {7'h00, ra_v + 16'h0002};
               `CPUCD_OP_RET: begin
                  hi_reg <= rdata[6:0];
                  if (ir_reg.sub[0]) begin
                     ie_reg <= 1'b1;
                  end
               end
               default: ;
            endcase
         end
      end
   end

   // checks
   prefetch_seq_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      CLK_EN && adv && !redirect |=> ex_pc_reg == $past(ip_reg) && ir_vld_reg)
      else $error("prefetched word not promoted");
   flush_stall_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      CLK_EN && redirect |=> !ir_vld_reg && ip_reg == $past(redir_tgt))
      else $error("flow change did not flush");
   repeat_hold_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      CLK_EN && ex && rep_live && ir_reg.op != `CPUCD_OP_REP
      |=> ex_pc_reg == $past(ex_pc_reg) && rep_reg == $past(rep_reg) - 14'h0001)
      else $error("repeat did not hold instruction");
   irq_keep_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      CLK_EN && take_irq |=> state_reg == ST_PUSH2 && rep_reg == $past(rep_reg)
      && div_step_reg == $past(div_step_reg))
      else $error("interrupt lost repeat or divide state");
   stack_push_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      CLK_EN && ex && ir_reg.op == `CPUCD_OP_CALL
      |=> wreg[15] == $past(wreg[15]) + 16'h0002 ##1 (!ir_vld_reg || state_reg == ST_PUSH2))
      else $error("call did not push through stack pointer");
   win_page_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      win_hit |-> PW_ADDR[21:14] == page_reg && daddr[15])
      else $error("window page not applied");
   win_load_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      CLK_EN && ex && ir_reg.op == `CPUCD_OP_LD && win_hit && rep_reg == 0
      |=> wreg[$past(ir_reg.rd)] == $past(PW_RDATA[15:0]))
      else $error("window load did not return program data");
   mul_result_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      CLK_EN && ex && ir_reg.op == `CPUCD_OP_MUL && ir_reg.sub[1:0] == 2'b00
      && ir_reg.rd != 4'hf
      |=> {wreg[$past(ir_reg.rd) + 4'h1], wreg[$past(ir_reg.rd)]}
          == $past(ra_v) * $past(rb_v))
      else $error("unsigned product wrong");
   div_done_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      CLK_EN && ex && ir_reg.op == `CPUCD_OP_DIV && div_step_reg == `CPUCD_DIV_LAST
      |=> div_step_reg == 5'h00 && wreg[0] == $past(div_quo_reg))
      else $error("divide did not finish on last step");
endmodule

// File: bench/cpucd_mem_model.sv
`timescale 1ns/1ns
module cpucd_mem_model (
   // clock
   input wire logic SYS_CLK,
   // program memory, fetch and window ports
   input wire logic [22:0] PM_ADDR,
   output logic [23:0] PM_RDATA,
   input wire logic [22:0] PW_ADDR,
   output logic [23:0] PW_RDATA,
   // data memory ports
   input wire logic [15:0] DM_RADDR,
   output logic [15:0] DM_RDATA,
   input wire cpucd_pkg::cpucd_dmw_s DM_WR
);
   import cpucd_pkg::*;
   // program words, filled by the bench; high address bits alias
   logic [23:0] prog [0:32767];
   // data words, indexed by byte address bits 15:1
   logic [15:0] dmem [0:32767];
   // fetch answered in the same cycle, no wait states
   assign PM_RDATA = prog[PM_ADDR[14:0]];
   // window port reads program space as plain words
   assign PW_RDATA = prog[PW_ADDR[14:0]];
   // data read beside the write in one cycle
   assign DM_RDATA = dmem[DM_RADDR[15:1]];
   // write lands at the rising edge, whole 16-bit word
   always @(posedge SYS_CLK) begin
      if (DM_WR.we === 1'b1)
         dmem[DM_WR.addr[15:1]] <= DM_WR.data;
   end
endmodule

// File: bench/cpucd_core_tb.sv
`timescale 1ns/1ns
module cpucd_core_tb;
   import cpucd_pkg::*;
   // stimulus
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic clk_en = 1'b1;
   logic irq_req = 1'b0;
   // core and memory wires
   logic [22:0] pm_addr, pw_addr;
   logic [23:0] pm_rdata, pw_rdata;
   logic [15:0] dm_raddr, dm_rdata;
   cpucd_dmw_s dm_wr;
   logic dma_flag, irq_ack, rep_busy;
   // bookkeeping
   int num_errors = 0;
   int tests_run = 0;
   int cyc = 0;
   int bn = 0;
   int pa, b_t, acks, dma_in, dma_out;
   bit irq_arm, stall_arm;
   logic [15:0] wa[$], wd[$];
   int wt[$];

   always #25 clk = ~clk;

   cpucd_core cpucd_core_inst (.SYS_CLK(clk), .RST_B(rst_b), .CLK_EN(clk_en), .PM_ADDR(pm_addr),
      .PM_RDATA(pm_rdata), .PW_ADDR(pw_addr), .PW_RDATA(pw_rdata), .DM_RADDR(dm_raddr),
      .DM_RDATA(dm_rdata), .DM_WR(dm_wr), .DM_DMA_REGION(dma_flag), .IRQ_REQ(irq_req),
      .IRQ_ACK(irq_ack), .REPEAT_BUSY(rep_busy));
   cpucd_mem_model cpucd_mem_model_inst (.SYS_CLK(clk), .PM_ADDR(pm_addr), .PM_RDATA(pm_rdata),
      .PW_ADDR(pw_addr), .PW_RDATA(pw_rdata), .DM_RADDR(dm_raddr), .DM_RDATA(dm_rdata),
      .DM_WR(dm_wr));

   // write log, flags and hang watch at the rising edge
   always @(posedge clk) begin
      cyc++;
      if (rst_b === 1'b1 && dm_wr.we === 1'b1) begin
         wa.push_back(dm_wr.addr);
         wd.push_back(dm_wr.data);
         wt.push_back(cyc);
      end
      if (rep_busy === 1'b1 && b_t < 0)
         b_t = cyc;
      if (irq_ack === 1'b1)
         acks++;
      if (dma_flag === 1'b1 && dm_raddr === 16'h4000)
         dma_in++;
      if (dma_flag === 1'b1 && (dm_raddr < 16'h4000 || dm_raddr > 16'h47ff))
         dma_out++;
      if (cyc > 5000) begin
         num_errors++;
         final_report();
      end
   end

   // interrupt request and enable stall, off the falling edge
   always @(negedge clk) begin
      bn = (rep_busy === 1'b1) ? bn + 1 : 0;
      // one request per run, dropped once the core has taken it
      if (irq_arm && bn == 5 && acks == 0)
         irq_req <= 1'b1;
      if (acks > 0)
         irq_req <= 1'b0;
      clk_en <= !(stall_arm && bn >= 2 && bn < 5);
   end

   task automatic final_report();
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chkn(input string n, input int e, input int g);
      tests_run++;
      if (g != e) begin
         num_errors++;
         $display("mismatch %s expected %0d seen %0d", n, e, g);
      end
   endtask

   task automatic cw(input int i, input logic [15:0] a, input logic [15:0] d);
      chk("write address", a, wa[i]);
      chk("write data", d, wd[i]);
   endtask

   // word load into a register
   function automatic logic [23:0] movi(input logic [3:0] r, input logic [15:0] v);
      return {4'h3, r, v[3:0], v[15:4]};
   endfunction

   // store a register at the address register 13 plus register 14
   function automatic logic [23:0] st(input logic [3:0] r);
      return {8'h50, r, 12'h0de};
   endfunction

   // clear program space, jump over the vector, isr returns
   task automatic boot();
      for (int i = 0; i < 32768; i++)
         cpucd_mem_model_inst.prog[i] = 24'h00_0000;
      cpucd_mem_model_inst.prog[0] = 24'h80_000f;
      cpucd_mem_model_inst.prog[4] = 24'he1_0000;
      pa = 16;
      cpucd_mem_model_inst.prog[pa] = movi(4'hd, 16'h0100);
      pa++;
   endtask

   task automatic e(input logic [23:0] w);
      cpucd_mem_model_inst.prog[pa] = w;
      pa++;
   endtask

   // reset for five cycles, then run
   task automatic go(input int n);
      wa.delete();
      wd.delete();
      wt.delete();
      b_t = -1;
      acks = 0;
      dma_in = 0;
      dma_out = 0;
      rst_b = 1'b0;
      repeat (5) @(negedge clk);
      rst_b = 1'b1;
      repeat (n) @(negedge clk);
      irq_arm = 1'b0;
      stall_arm = 1'b0;
   endtask

   task automatic t_alu();
      logic [15:0] ex[5] = '{16'h2224, 16'h0244, 16'h0230, 16'h1ff4, 16'h1dc4};
      boot();
      e(movi(4'h1, 16'h1234));
      e(movi(4'h2, 16'h0ff0));
      for (int f = 0; f < 5; f++) begin
         e({4'h1, f[3:0], 16'h3012});
         e(st(4'h3));
      end
      e(24'h20_d0d2);
      // double move of 0x100/0x102, then both conditions with zero clear
      e(movi(4'he, 16'h0002));
      e(st(4'h2));
      e(24'hd0_80d0);
      e(st(4'h8));
      e(st(4'h9));
      e(24'h81_0001);
      e(st(4'h1));
      e(24'h82_0001);
      e(st(4'h2));
      e(st(4'h3));
      go(40);
      chkn("write count", 11, wd.size());
      for (int f = 0; f < 5; f++) begin
         cw(f, 16'h0100, ex[f]);
         if (f > 0)
            chkn("alu spacing", 2, wt[f] - wt[f - 1]);
      end
      cw(5, 16'h0100, 16'h2db4);
      chkn("three operand spacing", 1, wt[5] - wt[4]);
      cw(6, 16'h0102, 16'h0ff0);
      cw(7, 16'h0102, 16'h2db4);
      cw(8, 16'h0102, 16'h0ff0);
      chkn("double move cycles", 3, wt[7] - wt[6]);
      cw(9, 16'h0102, 16'h1234);
      chkn("untaken branch", 2, wt[9] - wt[8]);
      cw(10, 16'h0102, 16'h1dc4);
      chkn("taken branch", 3, wt[10] - wt[9]);
   endtask

   task automatic t_mul();
      logic signed [16:0] x, y;
      logic signed [33:0] p;
      boot();
      e(movi(4'h1, 16'hffff));
      e(movi(4'h2, 16'h8000));
      for (int s = 0; s < 4; s++) begin
         e({4'h6, s[3:0], 16'h4012});
         e(st(4'h4));
         e(st(4'h5));
      end
      go(40);
      for (int s = 0; s < 4; s++) begin
         x = {s[0], 16'hffff};
         y = {s[1], 16'h8000};
         p = x * y;
         cw(2 * s, 16'h0100, p[15:0]);
         chk("product high", p[31:16], wd[2 * s + 1]);
      end
   endtask

   task automatic t_shf();
      logic [15:0] v = 16'h8421;
      logic [31:0] t;
      int n[4] = '{0, 1, 15, 16};
      int m[3] = '{1, 2, 0};
      boot();
      e(movi(4'h1, v));
      foreach (n[i]) begin
         e(movi(4'h2, 16'(n[i])));
         foreach (m[j]) begin
            e({4'h7, m[j][3:0], 16'h3012});
            e(st(4'h3));
         end
      end
      go(50);
      foreach (n[i]) begin
         foreach (m[j]) begin
            t = (m[j] == 2) ? {{16{v[15]}}, v} : {16'h0000, v};
            t = (m[j] == 1) ? t << n[i] : t >> n[i];
            chk("shift", t[15:0], wd[3 * i + j]);
         end
      end
   endtask

   task automatic t_flow();
      boot();
      e(movi(4'h1, 16'h0011));
      e(st(4'h1));
      e(24'h80_0001);
      e(st(4'hd));
      e(24'h90_0020);
      e(st(4'h1));
      e(24'h90_0020);
      e(24'h80_ffff);
      cpucd_mem_model_inst.prog[32] = 24'he0_0000;
      go(40);
      chkn("write count", 6, wd.size());
      cw(0, 16'h0100, 16'h0011);
      cw(1, 16'h0800, 16'h0016);
      cw(2, 16'h0802, 16'h0000);
      cw(4, 16'h0800, 16'h0018);
      chkn("branch stall", 3, wt[1] - wt[0]);
      chkn("call return stall", 6, wt[3] - wt[1]);
   endtask

   task automatic t_div(input bit irq);
      boot();
      e(movi(4'h1, 16'h03e8));
      e(movi(4'h2, 16'h0007));
      e(24'ha0_1001);
      e(24'hb0_0012);
      e(st(4'h0));
      e(st(4'h1));
      e(24'h80_ffff);
      irq_arm = irq;
      go(50);
      if (irq) begin
         chkn("interrupt taken", 1, acks);
         cw(0, 16'h0800, 16'h0014);
         cw(2, 16'h0100, 16'h008e);
         chk("remainder", 16'h0006, wd[3]);
      end else begin
         cw(0, 16'h0100, 16'h008e);
         chk("remainder", 16'h0006, wd[1]);
         chkn("divide cycles", 18, wt[0] - b_t);
      end
   endtask

   task automatic t_rep();
      boot();
      e(movi(4'h2, 16'h0001));
      e(24'ha0_3000);
      e(24'h10_1012);
      e(st(4'h1));
      e(24'h80_ffff);
      stall_arm = 1'b1;
      go(30);
      chk("repeat sum", 16'h0004, wd[0]);
      chkn("repeat cycles", 7, wt[0] - b_t);
   endtask

   task automatic t_win();
      boot();
      cpucd_mem_model_inst.prog['h4002] = 24'h5a_c3e1;
      e(24'hc0_0101);
      e(movi(4'h3, 16'h8004));
      e(24'h40_403e);
      e(st(4'h4));
      e(movi(4'h5, 16'h4000));
      e(24'h50_505e);
      e(24'h40_605e);
      e(st(4'h6));
      e(movi(4'h7, 16'h3ffe));
      e(24'h40_807e);
      e(movi(4'h7, 16'h4800));
      e(24'h40_807e);
      e(24'h80_ffff);
      go(40);
      chk("window read", 16'hc3e1, wd[0]);
      cw(1, 16'h4000, 16'h4000);
      chk("dma reuse", 16'h4000, wd[2]);
      chkn("dma flag inside", 1, dma_in > 0);
      chkn("dma flag outside", 0, dma_out);
   endtask

   // scenario sequence
   initial begin
      t_alu();
      t_mul();
      t_shf();
      t_flow();
      t_div(1'b0);
      t_div(1'b1);
      t_rep();
      t_win();
      final_report();
   end
endmodule
